// file: common/scm_pkg.sv
// Purpose: Shared constants and types for the sensor command mailbox.
// Assumes: Core clock of 100 MHz; six measurement channels.
// Notes: Parameter indices and error codes are fixed by this package.
package scm_pkg;
   // Slave addresses and the first-byte prefix of ten-bit addressing.
   localparam logic [6:0] ADDR_DEFAULT = 7'h55;
   localparam logic [6:0] ADDR_ALT = 7'h52;
   localparam logic [4:0] TEN_BIT_PFX = 5'h1e;
   // Command codes.
   localparam logic [7:0] CMD_CLR_CNT = 8'h00;
   localparam logic [7:0] CMD_SW_RESET = 8'h01;
   localparam logic [7:0] CMD_FORCE = 8'h11;
   localparam logic [7:0] CMD_PAUSE = 8'h12;
   localparam logic [7:0] CMD_START = 8'h13;
   localparam logic [7:0] CMD_STORE_ADDR = 8'h17;
   localparam logic [1:0] OP_QUERY = 2'h1;
   localparam logic [1:0] OP_SET = 2'h2;
   // Parameter table size, layout and output space.
   localparam logic [6:0] TABLE_BYTES = 7'h2c;
   localparam int NCHAN = 6;
   localparam logic [5:0] P_ADDR = 6'h00;
   localparam logic [5:0] P_CHANNEL_SELECT_LIST = 6'h01;
   localparam logic [5:0] P_SETUP = 6'h02;
   localparam logic [5:0] P_THRESH_LO = 6'h08;
   localparam logic [5:0] P_THRESH_HI = 6'h09;
   localparam logic [5:0] P_RATE = 6'h0a;
   localparam logic [6:0] OUT_SPACE = 7'h1a;
   // Completion status: error flag position, error codes, reset value.
   localparam int ERR_BIT = 4;
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_BAD_CMD = 4'h1;
   localparam logic [3:0] ERR_PARAM_ADDR = 4'h2;
   localparam logic [3:0] ERR_OUT_SPACE = 4'h3;
   localparam logic [4:0] STAT_RESET = 5'h0f;
   // Timing: one autonomous rate tick, and strap settle cycles.
   localparam int RATE_TICK_US = 100;
   localparam int CORE_PERIOD_NS = 10;
   localparam int RATE_TICK_CYC = RATE_TICK_US * 1000 / CORE_PERIOD_NS;
   localparam logic [1:0] INIT_CYC = 2'h2;
   typedef enum logic [0:0] {
      ST_INIT = 1'b0,
      ST_RUN = 1'b1
   } scm_state_t;
   // One byte written by the host: command byte or input byte.
   typedef struct packed {
      logic is_cmd;
      logic [7:0] data;
   } scm_req_t;
   // One measurement result.
   typedef struct packed {
      logic [2:0] chan;
      logic [15:0] value;
   } scm_result_t;
endpackage

// file: hw/scm_mailbox.sv
// Purpose: Command interpreter, parameter table and address logic of the sensor.
// Assumes: Link side runs on link_clk; rstn resets both domains asynchronously.
// Notes: Host bytes cross by a toggle handshake, one byte in flight at a time.

// Summary of operation
// - Start command puts listed channels that have a counter index into repeated autonomous measurement.
// - Autonomous results update result register and raise new-data interrupt if enabled.
// - Result at or above preset threshold raises interrupt if enabled.
// - Slave address can be reprogrammed; hard or soft reset restores original.
// - Only 7-bit addressing is decoded; ten-bit prefixes are never acknowledged.
// - Device answers on default address 0x55 or alternate 0x52.
// - Strap level caught at initialization picks default or alternate address.
// - Parameter table of 0x2c bytes, reached one byte per command.
// - Parameter table is cleared by power-down and by software reset.
// - Bad parameter address or output space over 26 bytes sets error.
// - Successful command increments the completion counter.
// - Counter sits in bits 3:0; clear and reset commands do not count.
// - With error flag set, bits 3:0 hold the error code.
// - Code 0x00 clears the completion counter.
// - Code 0x01 resets the device, leaving counter nibble at 1111.
// - Software reset restores table and all visible registers to defaults.
// - Code 0x11 measures enabled channels that have no counter index.
// - Code 0x12 pauses autonomous measurement of listed channels.
// - Code 0x13 starts listed channels that have a counter index.
// - Code 01xxxxxx copies parameter xxxxxx into the readback register.
// - Code 10xxxxxx writes input byte to parameter and readback register.
// - New slave address is taken from its parameter on the store command.
module scm_mailbox #(
   parameter int RATE_TICK_CYC = scm_pkg::RATE_TICK_CYC
) (
   // Core clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Strap pin selecting the slave address.
   input wire logic address_strap_pin,
   // Link side, on link_clk.
   input wire logic link_clk,
   input wire logic lnk_wr,
   input wire scm_pkg::scm_req_t lnk_req,
   output logic lnk_ready,
   input wire logic lnk_addr_valid,
   input wire logic [7:0] lnk_addr_byte,
   output logic lnk_addr_ack,
   // Host-visible registers.
   output logic [7:0] completion_status_reg,
   output logic [7:0] readback_reg,
   output logic [6:0] slave_address,
   // Measurement engine.
   output logic meas_start,
   output logic [5:0] meas_mask,
   input wire logic res_valid,
   input wire scm_pkg::scm_result_t res_in,
   output scm_pkg::scm_result_t result_reg,
   // Interrupt enables, clear and open-drain pin.
   input wire logic [1:0] irq_enable,
   input wire logic irq_clear,
   output logic int_o,
   output logic int_oe
);
   // ---------------- Link domain ----------------
   scm_pkg::scm_req_t req_data_r;
   logic req_tog_r, ack_s1_r, ack_s2_r, ready_r, addr_ack_r;
   logic at_s1_r, at_s2_r, at_s3_r;
   logic [6:0] lnk_addr_r;
   // Core domain state referenced by the link side.
   logic ack_tog_r, addr_tog_r;
   logic [6:0] addr_r;

   wire take = lnk_wr && ready_r;
   wire ten_bit = lnk_addr_byte[7:3] == scm_pkg::TEN_BIT_PFX;
   wire addr_hit = !ten_bit && (lnk_addr_byte[7:1] == lnk_addr_r);

   // A byte is held stable in req_data_r until the core toggles its ack back.
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         req_data_r <= '0;
         req_tog_r <= 1'b0;
         ready_r <= 1'b0;
      end else begin
         if (take) begin
            req_data_r <= lnk_req;
            req_tog_r <= ~req_tog_r;
         end
         ready_r <= !take && (req_tog_r == ack_s2_r);
      end
   end

   // Ack toggle and address-change toggle synchronisers.
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         at_s1_r <= 1'b0;
         at_s2_r <= 1'b0;
         at_s3_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tog_r;
         ack_s2_r <= ack_s1_r;
         at_s1_r <= addr_tog_r;
         at_s2_r <= at_s1_r;
         at_s3_r <= at_s2_r;
      end
   end

   // The core changes addr_r only together with a toggle, so the word is
   // stable by the time the synchronised toggle edge arrives here.
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         lnk_addr_r <= scm_pkg::ADDR_DEFAULT;
         addr_ack_r <= 1'b0;
      end else begin
         if (at_s2_r != at_s3_r) lnk_addr_r <= addr_r;
         addr_ack_r <= lnk_addr_valid && addr_hit;
      end
   end

   assign lnk_ready = ready_r;
   assign lnk_addr_ack = addr_ack_r;

   a_ten_bit_nack: assert property (@(posedge link_clk) disable iff (!rstn)
      lnk_addr_valid && ten_bit |=> !lnk_addr_ack)
      else $error("Ten-bit address was acknowledged.");

   // ---------------- Core domain ----------------
   scm_pkg::scm_state_t st_r;
   logic [1:0] init_cnt_r;
   logic strap_s1_r, strap_s2_r, req_s1_r, req_s2_r;
   logic [7:0] param_r [0:43];
   logic [7:0] hin_r, readback_r;
   logic [4:0] status_r;
   logic [5:0] auto_mask_r, meas_mask_r;
   logic meas_start_r, int_oe_r;
   logic [31:0] tick_cnt_r;
   logic [7:0] period_cnt_r;
   scm_pkg::scm_result_t result_r;

   // Output bytes one channel needs: width two or three, times burst 1..4.
   function automatic logic [6:0] ch_bytes(input logic [7:0] setup);
      ch_bytes = 7'({5'h0, 2'h2} + {6'h0, setup[5]}) * 7'({5'h0, setup[4:3]} + 7'h1);
   endfunction

   // Command decode.
   wire do_op = (st_r == scm_pkg::ST_RUN) && (req_s2_r != ack_tog_r);
   wire is_cmd = do_op && req_data_r.is_cmd;
   wire [7:0] code = req_data_r.data;
   wire [5:0] pidx = code[5:0];
   wire c_clr = is_cmd && code == scm_pkg::CMD_CLR_CNT;
   wire c_sw = is_cmd && code == scm_pkg::CMD_SW_RESET;
   wire c_force = is_cmd && code == scm_pkg::CMD_FORCE;
   wire c_pause = is_cmd && code == scm_pkg::CMD_PAUSE;
   wire c_start = is_cmd && code == scm_pkg::CMD_START;
   wire c_store = is_cmd && code == scm_pkg::CMD_STORE_ADDR;
   wire c_query = is_cmd && code[7:6] == scm_pkg::OP_QUERY;
   wire c_set = is_cmd && code[7:6] == scm_pkg::OP_SET;
   wire c_bad = is_cmd && !(c_clr || c_sw || c_force || c_pause || c_start || c_store
                            || c_query || c_set);
   wire addr_bad = {1'b0, pidx} >= scm_pkg::TABLE_BYTES;
   wire [7:0] q_val = addr_bad ? 8'h00 : param_r[pidx];

   // Channel selection from the list and per-channel setups.
   wire [5:0] channel_select_list = param_r[scm_pkg::P_CHANNEL_SELECT_LIST][5:0];
   logic [5:0] counted;
   logic [6:0] need_bytes;
   always_comb begin
      counted = '0;
      need_bytes = '0;
      for (int c = 0; c < scm_pkg::NCHAN; c++) begin
         counted[c] = param_r[scm_pkg::P_SETUP + 6'(c)][7:6] != 2'h0;
         if (channel_select_list[c]) need_bytes = need_bytes + ch_bytes(param_r[scm_pkg::P_SETUP + 6'(c)]);
      end
   end
   wire cfg_bad = need_bytes > scm_pkg::OUT_SPACE;
   wire [5:0] force_mask = channel_select_list & ~counted;
   wire [5:0] start_mask = channel_select_list & counted;

   // Outcome of a command: error code, or a counted success.
   wire [3:0] err_code = c_bad ? scm_pkg::ERR_BAD_CMD :
                         ((c_query || c_set) && addr_bad) ? scm_pkg::ERR_PARAM_ADDR :
                         ((c_force || c_start) && cfg_bad) ? scm_pkg::ERR_OUT_SPACE :
                         scm_pkg::ERR_NONE;
   wire failed = err_code != scm_pkg::ERR_NONE;
   wire counts = is_cmd && !failed && !c_clr && !c_sw;
   wire [4:0] status_nxt = c_clr ? 5'h00 :
                           failed ? {1'b1, err_code} :
                           (counts && !status_r[scm_pkg::ERR_BIT]) ?
                           {1'b0, status_r[3:0] + 4'h1} : status_r;

   // Autonomous timing: a fixed tick, scaled by the rate parameter.
   wire tick = tick_cnt_r == 32'(RATE_TICK_CYC - 1);
   wire auto_fire = tick && (auto_mask_r != 6'h0) && (period_cnt_r == 8'h00);
   wire force_go = c_force && !failed;
   wire [15:0] thresh = {param_r[scm_pkg::P_THRESH_HI], param_r[scm_pkg::P_THRESH_LO]};
   wire irq_evt = res_valid && (irq_enable[0] ||
                  (irq_enable[1] && res_in.value >= thresh));
   wire soft_rst = c_sw || st_r == scm_pkg::ST_INIT;

   // Strap and request toggle synchronisers.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
      end else begin
         strap_s1_r <= address_strap_pin;
         strap_s2_r <= strap_s1_r;
         req_s1_r <= req_tog_r;
         req_s2_r <= req_s1_r;
      end
   end

   // Initialization waits for the strap to settle, then latches the address.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= scm_pkg::ST_INIT;
         init_cnt_r <= 2'h0;
         addr_r <= scm_pkg::ADDR_DEFAULT;
         addr_tog_r <= 1'b0;
      end else begin
         case (st_r)
            scm_pkg::ST_INIT: begin
               init_cnt_r <= init_cnt_r + 2'h1;
               if (init_cnt_r == scm_pkg::INIT_CYC) begin
                  st_r <= scm_pkg::ST_RUN;
                  addr_r <= strap_s2_r ? scm_pkg::ADDR_DEFAULT : scm_pkg::ADDR_ALT;
                  addr_tog_r <= ~addr_tog_r;
               end
            end
            scm_pkg::ST_RUN: begin
               init_cnt_r <= 2'h0;
               if (c_sw) st_r <= scm_pkg::ST_INIT;
               if (c_store) begin
                  addr_r <= param_r[scm_pkg::P_ADDR][6:0];
                  addr_tog_r <= ~addr_tog_r;
               end
            end
            default: st_r <= scm_pkg::ST_INIT;
         endcase
      end
   end

   // Handshake ack: every taken byte is answered, software reset included.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) ack_tog_r <= 1'b0;
      else if (do_op) ack_tog_r <= ~ack_tog_r;
   end

   // Parameter table; cleared on software reset.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 44; i++) param_r[i] <= 8'h00;
      end else if (c_sw) begin
         for (int i = 0; i < 44; i++) param_r[i] <= 8'h00;
      end else if (c_set && !addr_bad) begin
         param_r[pidx] <= hin_r;
      end
   end

   // Mailbox registers.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hin_r <= 8'h00;
         readback_r <= 8'h00;
         status_r <= scm_pkg::STAT_RESET;
      end else if (c_sw) begin
         hin_r <= 8'h00;
         readback_r <= 8'h00;
         status_r <= scm_pkg::STAT_RESET;
      end else begin
         if (do_op && !req_data_r.is_cmd) hin_r <= req_data_r.data;
         if (c_query && !addr_bad) readback_r <= q_val;
         if (c_set && !addr_bad) readback_r <= hin_r;
         status_r <= status_nxt;
      end
   end

   // Autonomous channel set and rate counters.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         auto_mask_r <= 6'h0;
         tick_cnt_r <= 32'h0;
         period_cnt_r <= 8'h00;
      end else if (soft_rst) begin
         auto_mask_r <= 6'h0;
         tick_cnt_r <= 32'h0;
         period_cnt_r <= 8'h00;
      end else begin
         if (c_start && !failed) auto_mask_r <= auto_mask_r | start_mask;
         if (c_pause) auto_mask_r <= auto_mask_r & ~channel_select_list;
         tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
         if (tick) period_cnt_r <= (period_cnt_r == 8'h00) ? param_r[scm_pkg::P_RATE] :
                                   period_cnt_r - 8'h01;
      end
   end

   // Measurement requests, results and interrupt pin.
   // A force and an autonomous slot in the same cycle merge into one request.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meas_start_r <= 1'b0;
         meas_mask_r <= 6'h0;
         result_r <= '0;
         int_oe_r <= 1'b0;
      end else if (soft_rst) begin
         meas_start_r <= 1'b0;
         meas_mask_r <= 6'h0;
         result_r <= '0;
         int_oe_r <= 1'b0;
      end else begin
         meas_start_r <= force_go || auto_fire;
         meas_mask_r <= (force_go ? force_mask : 6'h0) | (auto_fire ? auto_mask_r : 6'h0);
         if (res_valid) result_r <= res_in;
         int_oe_r <= irq_evt || (int_oe_r && !irq_clear);
      end
   end

   assign completion_status_reg = {3'h0, status_r};
   assign readback_reg = readback_r;
   assign slave_address = addr_r;
   assign meas_start = meas_start_r;
   assign meas_mask = meas_mask_r;
   assign result_reg = result_r;
   assign int_o = 1'b0;
   assign int_oe = int_oe_r;

   // Checks on the command interpreter.
   a_clr_zeroes_cnt: assert property (@(posedge core_clk) disable iff (!rstn)
      c_clr |=> status_r == 5'h00)
      else $error("Counter clear did not zero the status.");
   a_swrst_nibble: assert property (@(posedge core_clk) disable iff (!rstn)
      c_sw |=> status_r == 5'h0f ##1 st_r == scm_pkg::ST_INIT)
      else $error("Software reset left a wrong status.");
   a_cnt_increment: assert property (@(posedge core_clk) disable iff (!rstn)
      counts && !status_r[4] |=> status_r[3:0] == $past(status_r[3:0]) + 4'h1)
      else $error("Successful command did not count.");
   a_bad_cmd_err: assert property (@(posedge core_clk) disable iff (!rstn)
      c_bad |=> status_r == 5'h11)
      else $error("Undefined command not flagged.");
   a_query_readback: assert property (@(posedge core_clk) disable iff (!rstn)
      c_query && !addr_bad |=> readback_reg == $past(q_val))
      else $error("Query result missing from readback.");
   a_set_copy: assert property (@(posedge core_clk) disable iff (!rstn)
      c_set && !addr_bad |=> readback_reg == $past(hin_r))
      else $error("Set byte not copied to readback.");
   a_param_addr_err: assert property (@(posedge core_clk) disable iff (!rstn)
      (c_query || c_set) && addr_bad |=> status_r == 5'h12)
      else $error("Out-of-table address not flagged.");
   a_auto_start: assert property (@(posedge core_clk) disable iff (!rstn)
      c_start && !failed |=> (auto_mask_r & $past(start_mask)) == $past(start_mask))
      else $error("Start did not enable counted channels.");
   a_pause_clears: assert property (@(posedge core_clk) disable iff (!rstn)
      c_pause |=> (auto_mask_r & $past(channel_select_list)) == 6'h0)
      else $error("Pause left listed channels running.");
   a_force_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
      force_go |=> meas_start ##1 (!meas_start || $past(auto_fire)))
      else $error("Force did not issue one request.");
endmodule // scm_mailbox

// file: testbench/scm_host_model.sv
// Purpose: Host-side model that writes mailbox bytes and probes slave addresses on the link.
// Assumes: Link inputs change only by non-blocking assignment at a link_clk rising edge.
// Notes: Released data lines carry the inverse of the last value, never a stale copy.
module scm_host_model (
   // Link clock.
   input wire logic link_clk,
   // Byte write path.
   output logic lnk_wr,
   output scm_pkg::scm_req_t lnk_req,
   input wire logic lnk_ready,
   // Address probe path.
   output logic lnk_addr_valid,
   output logic [7:0] lnk_addr_byte,
   input wire logic lnk_addr_ack
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle lines from time zero.
   initial begin
      lnk_wr = 1'b0;
      lnk_req = '0;
      lnk_addr_valid = 1'b0;
      lnk_addr_byte = 8'h00;
   end

   // Writes one byte, then waits for ready to drop and return before the caller reads status,
   // so no second byte is ever in flight.
   task automatic send_byte(input logic c, input logic [7:0] d, output bit ok);
      int n;
      bit low;
      low = 1'b0;
      n = 0;
      do begin
         @(posedge link_clk);
         n++;
      end while (lnk_ready !== 1'b1 && n < 40);
      lnk_wr <= 1'b1;
      lnk_req <= {c, d};
      @(posedge link_clk);
      lnk_wr <= 1'b0;
      lnk_req <= ~{c, d};
      while (n < 80 && !(low && lnk_ready === 1'b1)) begin
         @(posedge link_clk);
         low |= (lnk_ready === 1'b0);
         n++;
      end
      ok = low && (lnk_ready === 1'b1);
   endtask

   // Presents one address byte for one cycle and returns the acknowledge seen a cycle later.
   task automatic probe(input logic [7:0] b, output logic ack);
      @(posedge link_clk);
      lnk_addr_valid <= 1'b1;
      lnk_addr_byte <= b;
      @(posedge link_clk);
      lnk_addr_valid <= 1'b0;
      lnk_addr_byte <= ~b;
      @(posedge link_clk);
      ack = lnk_addr_ack;
   endtask
endmodule // scm_host_model

// file: testbench/scm_mailbox_test.sv
// Purpose: Self-checking bench for the sensor command mailbox.
// Assumes: Rate tick shortened to 8 core cycles; link clock of 64 ns.
// Notes: Status is read after the link handshake returns, as a polling host would, except the first check after reset.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module scm_mailbox_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rstn = 1'b0;
   logic strap = 1'b1;
   logic res_valid = 1'b0;
   scm_pkg::scm_result_t res_in = '0;
   logic [1:0] irq_enable = 2'h0;
   logic irq_clear = 1'b0;
   logic lnk_wr, lnk_ready, lnk_addr_valid, lnk_addr_ack, meas_start, int_o, int_oe, ack;
   scm_pkg::scm_req_t lnk_req;
   logic [7:0] lnk_addr_byte, status, readback;
   logic [6:0] slave_address;
   logic [5:0] meas_mask, last_mask;
   scm_pkg::scm_result_t result_reg;
   int bad_count = 0;
   int n_checks = 0;
   int starts = 0;

   // Free-running clocks of unrelated phase.
   always #5 core_clk = ~core_clk;
   always #32 link_clk = ~link_clk;

   scm_mailbox #(.RATE_TICK_CYC(8)) scm_mailbox_inst (.core_clk(core_clk), .rstn(rstn),
      .address_strap_pin(strap), .link_clk(link_clk), .lnk_wr(lnk_wr), .lnk_req(lnk_req),
      .lnk_ready(lnk_ready), .lnk_addr_valid(lnk_addr_valid), .lnk_addr_byte(lnk_addr_byte),
      .lnk_addr_ack(lnk_addr_ack), .completion_status_reg(status), .readback_reg(readback),
      .slave_address(slave_address), .meas_start(meas_start), .meas_mask(meas_mask),
      .res_valid(res_valid), .res_in(res_in), .result_reg(result_reg),
      .irq_enable(irq_enable), .irq_clear(irq_clear), .int_o(int_o), .int_oe(int_oe));
   scm_host_model scm_host_model_inst (.link_clk(link_clk), .lnk_wr(lnk_wr),
      .lnk_req(lnk_req), .lnk_ready(lnk_ready), .lnk_addr_valid(lnk_addr_valid),
      .lnk_addr_byte(lnk_addr_byte), .lnk_addr_ack(lnk_addr_ack));

   // Counts measurement starts and keeps the last channel mask.
   always @(posedge core_clk) begin
      if (meas_start === 1'b1) begin
         starts++;
         last_mask = meas_mask;
      end
   end

   // A hung handshake counts as a mismatch and ends the run.
   task automatic cmd(input logic c, input logic [7:0] d);
      bit ok;
      scm_host_model_inst.send_byte(c, d, ok);
      if (!ok) begin
         bad_count++;
         report_and_stop();
      end
   endtask

   // The input byte always goes ahead of its set command.
   task automatic setp(input logic [5:0] a, input logic [7:0] v);
      cmd(1'b0, v);
      cmd(1'b1, {scm_pkg::OP_SET, a});
   endtask

   task automatic soft_reset();
      cmd(1'b1, scm_pkg::CMD_SW_RESET);
      repeat (10) @(posedge core_clk);
   endtask

   task automatic pulse_res(input logic [15:0] v);
      @(posedge core_clk);
      res_valid <= 1'b1;
      res_in <= {3'h1, v};
      @(posedge core_clk);
      res_valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic t_param();
      cmd(1'b1, scm_pkg::CMD_CLR_CNT);
      `CHK(status, 8'h00)
      setp(6'h15, 8'ha5);
      `CHK(readback, 8'ha5)
      `CHK(status, 8'h01)
      setp(6'h16, 8'h3c);
      cmd(1'b1, {scm_pkg::OP_QUERY, 6'h15});
      `CHK(readback, 8'ha5)
      `CHK(status, 8'h03)
      setp(6'h2b, 8'h77);
      `CHK(status, 8'h04)
      cmd(1'b1, {scm_pkg::OP_QUERY, 6'h2b});
      `CHK(readback, 8'h77)
      cmd(1'b1, {scm_pkg::OP_QUERY, 6'h2c});
      `CHK(status, 8'h12)
      cmd(1'b1, scm_pkg::CMD_CLR_CNT);
      `CHK(status, 8'h00)
      cmd(1'b1, 8'h05);
      `CHK(status, 8'h11)
      cmd(1'b1, scm_pkg::CMD_CLR_CNT);
      cmd(1'b1, 8'hc0);
      `CHK(status, 8'h11)
      $display("test param done");
   endtask

   task automatic t_addr();
      scm_host_model_inst.probe({scm_pkg::ADDR_DEFAULT, 1'b0}, ack);
      `CHK(ack, 1'b1)
      scm_host_model_inst.probe({scm_pkg::ADDR_ALT, 1'b1}, ack);
      `CHK(ack, 1'b0)
      setp(scm_pkg::P_ADDR, 8'h78);
      cmd(1'b1, scm_pkg::CMD_STORE_ADDR);
      `CHK(slave_address, 7'h78)
      scm_host_model_inst.probe(8'hf0, ack);
      `CHK(ack, 1'b0)
      setp(scm_pkg::P_ADDR, 8'h2a);
      cmd(1'b1, scm_pkg::CMD_STORE_ADDR);
      scm_host_model_inst.probe(8'h55, ack);
      `CHK(ack, 1'b1)
      soft_reset();
      `CHK(slave_address, 7'h55)
      `CHK(status, 8'h0f)
      `CHK(readback, 8'h00)
      cmd(1'b1, {scm_pkg::OP_QUERY, scm_pkg::P_ADDR});
      `CHK(readback, 8'h00)
      `CHK(status, 8'h00)
      @(posedge core_clk) strap <= 1'b0;
      soft_reset();
      `CHK(slave_address, 7'h52)
      scm_host_model_inst.probe({scm_pkg::ADDR_ALT, 1'b0}, ack);
      `CHK(ack, 1'b1)
      @(posedge core_clk) strap <= 1'b1;
      soft_reset();
      `CHK(slave_address, 7'h55)
      $display("test addr done");
   endtask

   // A rate of one fires every second tick, which exercises the period reload.
   task automatic t_meas();
      setp(scm_pkg::P_CHANNEL_SELECT_LIST, 8'h03);
      setp(scm_pkg::P_SETUP, 8'h00);
      setp(scm_pkg::P_SETUP + 6'h1, 8'h40);
      setp(scm_pkg::P_RATE, 8'h01);
      starts = 0;
      cmd(1'b1, scm_pkg::CMD_FORCE);
      `CHK(starts, 1)
      `CHK(last_mask, 6'h01)
      cmd(1'b1, scm_pkg::CMD_START);
      starts = 0;
      repeat (100) @(posedge core_clk);
      `CHK(starts >= 6 && starts <= 7, 1'b1)
      `CHK(last_mask, 6'h02)
      cmd(1'b1, scm_pkg::CMD_PAUSE);
      starts = 0;
      repeat (100) @(posedge core_clk);
      `CHK(starts, 0)
      for (int i = 0; i < 3; i++) setp(scm_pkg::P_SETUP + 6'(i), 8'h38);
      setp(scm_pkg::P_CHANNEL_SELECT_LIST, 8'h07);
      cmd(1'b1, scm_pkg::CMD_FORCE);
      `CHK(status, 8'h13)
      cmd(1'b1, scm_pkg::CMD_CLR_CNT);
      $display("test meas done");
   endtask

   // Ends with a pending interrupt that a software reset must withdraw.
   task automatic t_irq();
      @(posedge core_clk) irq_enable <= 2'h1;
      pulse_res(16'h1234);
      `CHK(result_reg, {3'h1, 16'h1234})
      `CHK(int_oe, 1'b1)
      irq_clear <= 1'b1;
      @(posedge core_clk) irq_clear <= 1'b0;
      @(posedge core_clk);
      `CHK(int_oe, 1'b0)
      setp(scm_pkg::P_THRESH_LO, 8'h00);
      setp(scm_pkg::P_THRESH_HI, 8'h01);
      @(posedge core_clk) irq_enable <= 2'h2;
      pulse_res(16'h00ff);
      `CHK(int_oe, 1'b0)
      pulse_res(16'h0100);
      `CHK(int_oe, 1'b1)
      `CHK(int_o, 1'b0)
      soft_reset();
      `CHK(int_oe, 1'b0)
      `CHK(result_reg, 19'h0)
      $display("test irq done");
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence: reset, let initialization finish, then run each test.
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (10) @(posedge core_clk);
      `CHK(status, 8'h0f)
      `CHK(slave_address, 7'h55)
      `CHK(int_oe, 1'b0)
      t_param();
      t_addr();
      t_meas();
      t_irq();
      report_and_stop();
   end
endmodule // scm_mailbox_test
